// >>> port_jk_defines.svh
`ifndef PORT_JK_DEFINES_SVH
`define PORT_JK_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_PORT_DATA   8'h00
`define ADDR_PORT_DIR    8'h04
`define ADDR_PORT_FUNC   8'h08
`define ADDR_PIN_LEVEL   8'h0C
`define ADDR_PIN_OE      8'h10
`define ADDR_PERIPH_OE   8'h14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PORT_DATA    16'h0000
`define RST_PORT_DIR     16'h0000
`define RST_PORT_FUNC    2'h3

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define FUNC_J_BIT       0
`define FUNC_K_BIT       1
`define IO_DISABLE_BIT   3
`define IO_NO_OUTPUT     2'h0
`define CKE_CLOCK_OUT    2'h1
`define CSS_CS_OUT       2'h2
`define CSS_CS_AUTO      2'h3
`define POE_CS_BIT       0
`define POE_TXD_BIT      1
`define POE_SCK_BIT      2
`define POE_PO15_BIT     3

`endif

// >>> port_jk_pkg.sv
package port_jk_pkg;

	// State of the pin multiplexer, except the input synchroniser stages
	typedef struct packed {
		logic [15:0] data;    // Port output data, K high byte
		logic [15:0] dir;     // Per-pin direction bits
		logic [1:0]  func;    // Port function control A
		logic [15:0] pin_out; // Registered pin output level
		logic [15:0] pin_oe;  // Registered pin output enable
		logic [3:0]  per_oe;  // Serial and pulse output enables
		logic        ack;     // Bus acknowledge
		logic [31:0] rdat;    // Bus read data
	} mux_state_t;

endpackage

// >>> timer_field_oe.sv
`include "port_jk_defines.svh"

module timer_field_oe (
	input  wire logic [3:0] io_control_i,    // Channel I/O-control field
	input  wire logic       buffer_mode_i,   // Buffer mode, 0 for A/B
	output logic            output_enable_o  // Timer owns the pin
);

	// ----------------------------------------
	// Output-enable decode
	// ----------------------------------------
	// Bit 3 clear and a non-zero output code
	assign output_enable_o = !buffer_mode_i
		&& !io_control_i[`IO_DISABLE_BIT]
		&& (io_control_i[1:0] != `IO_NO_OUTPUT);

endmodule

// >>> pin_sync.sv
module pin_sync #(
	parameter int WIDTH = 16 // Number of pins
) (
	input  wire logic             clk_i, // System clock
	input  wire logic             rst_i, // Synchronous reset
	input  wire logic [WIDTH-1:0] d_i,   // Raw pin levels
	output logic      [WIDTH-1:0] q_o    // Synchronised levels
);

	// Two stages, first read only by second
	typedef struct packed {
		logic [WIDTH-1:0] s1; // First stage
		logic [WIDTH-1:0] s2; // Second stage
	} sync_state_t;

	sync_state_t st;      // Current state
	sync_state_t next_st; // Next state

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Input level always available to peripherals
	assign q_o = st.s2;

	property p_sync_delay;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i ##1 !rst_i |=> (q_o == $past(d_i, 2));
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("pin level not passed after two stages");

endmodule

// >>> port_jk_pin_function_mux.sv
`include "port_jk_defines.svh"

module port_jk_pin_function_mux #(
	parameter int NPINS = 16 // Port J and port K pins
) (
	input  wire logic        clk_i,       // System clock
	input  wire logic        rst_i,       // Synchronous reset
	// Wishbone slave
	input  wire logic        wb_cyc_i,    // Bus cycle
	input  wire logic        wb_stb_i,    // Strobe
	input  wire logic        wb_we_i,     // Write enable
	input  wire logic [7:0]  wb_adr_i,    // Byte address
	input  wire logic [3:0]  wb_sel_i,    // Byte lanes
	input  wire logic [31:0] wb_dat_i,    // Write data
	output logic      [31:0] wb_dat_o,    // Read data
	output logic             wb_ack_o,    // Acknowledge
	// Timer channels 6 to 11, index 0 to 5
	input  wire logic [23:0] tmr_io_a_i,  // A I/O-control fields
	input  wire logic [23:0] tmr_io_b_i,  // B I/O-control fields
	input  wire logic [7:0]  tmr_io_c_i,  // C fields, ch 6 and 9
	input  wire logic [7:0]  tmr_io_d_i,  // D fields, ch 6 and 9
	input  wire logic [1:0]  buffer_mode_a_i, // ch 6 and 9
	input  wire logic [1:0]  buffer_mode_b_i, // ch 6 and 9
	input  wire logic [5:0]  tmr_out_a_i, // A compare outputs
	input  wire logic [5:0]  tmr_out_b_i, // B compare outputs
	input  wire logic [1:0]  tmr_out_c_i, // C outputs, ch 6 and 9
	input  wire logic [1:0]  tmr_out_d_i, // D outputs, ch 6 and 9
	// Synchronous serial unit
	input  wire logic        master_select_i,        // Master mode
	input  wire logic        chip_select_field_hi_i, // Field bit 1
	input  wire logic        chip_select_field_lo_i, // Field bit 0
	input  wire logic        sync_serial_mode_select_i, // Mode
	// Serial interface
	input  wire logic        transmit_enable_bit_i,  // Transmit on
	input  wire logic        receive_enable_bit_i,   // Receive on
	input  wire logic [1:0]  clock_enable_field_i,   // Clock source
	input  wire logic        smart_card_interface_select_i, // Card
	input  wire logic        smart_card_mode_bit_i,  // Card mode
	input  wire logic        sync_mode_bit_i,        // 1 = clocked
	input  wire logic        next_data_enable_15_i,  // Pulse bit 15
	// Pins, J in low byte, K in high byte
	input  wire logic [15:0] pin_in_i,    // Pin levels
	output logic      [15:0] pin_out_o,   // Pin drive level
	output logic      [15:0] pin_oe_o,    // Pin drive enable
	output logic      [15:0] pin_level_o, // Synced pin levels
	output logic             chip_select_output_enable_o,  // SYNC_SERIAL_UNIT
	output logic             transmit_pin_output_enable_o, // Tx
	output logic             serial_clock_output_enable_o, // Clock
	output logic             pulse_out15_enable_o          // Pulse
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (NPINS != 16) begin : g_bad_npins
		$error("NPINS must be 16");
	end

	port_jk_pkg::mux_state_t st;      // Current state
	port_jk_pkg::mux_state_t next_st; // Next state

	// State after reset: all pins inputs
	localparam port_jk_pkg::mux_state_t RESET_ST = '{
		data:    `RST_PORT_DATA,
		dir:     `RST_PORT_DIR,
		func:    `RST_PORT_FUNC,
		default: '0
	};

	logic [5:0]  oe_a;      // Per-channel A enables
	logic [5:0]  oe_b;      // Per-channel B enables
	logic [1:0]  oe_c;      // C enables, ch 6 and 9
	logic [1:0]  oe_d;      // D enables, ch 6 and 9
	logic [15:0] raw_oe;    // Timer enables in pin order
	logic [15:0] tmr_out;   // Timer outputs in pin order
	logic [15:0] func_mask; // Port function control per pin
	logic [15:0] eff_oe;    // Timer owns the pin
	logic [15:0] gpo_sel;   // General-purpose output pins
	logic [15:0] idle_sel;  // General-purpose input pins
	logic [15:0] sync_lvl;  // Synchronised pin levels
	logic [1:0]  css;       // Chip-select field
	logic        bus_req;   // New bus request
	logic [15:0] lane_mask; // Write byte lanes as bits

	// ----------------------------------------
	// Timer output-enable decode
	// ----------------------------------------
	// A and B fields for each channel
	for (genvar ch = 0; ch < 6; ch++) begin : g_ab
		timer_field_oe u_a (
			.io_control_i    (tmr_io_a_i[ch*4 +: 4]),
			.buffer_mode_i   (1'b0),
			.output_enable_o (oe_a[ch])
		);
		timer_field_oe u_b (
			.io_control_i    (tmr_io_b_i[ch*4 +: 4]),
			.buffer_mode_i   (1'b0),
			.output_enable_o (oe_b[ch])
		);
	end

	// C and D fields, gated by buffer mode
	for (genvar cd = 0; cd < 2; cd++) begin : g_cd
		timer_field_oe u_c (
			.io_control_i    (tmr_io_c_i[cd*4 +: 4]),
			.buffer_mode_i   (buffer_mode_a_i[cd]),
			.output_enable_o (oe_c[cd])
		);
		timer_field_oe u_d (
			.io_control_i    (tmr_io_d_i[cd*4 +: 4]),
			.buffer_mode_i   (buffer_mode_b_i[cd]),
			.output_enable_o (oe_d[cd])
		);
	end

	// ----------------------------------------
	// Pin ownership map
	// ----------------------------------------
	// J: A6 B6 C6 D6 A7 B7 A8 B8; K: A9 .. B11
	assign raw_oe = {oe_b[5], oe_a[5], oe_b[4], oe_a[4],
		oe_d[1], oe_c[1], oe_b[3], oe_a[3],
		oe_b[2], oe_a[2], oe_b[1], oe_a[1],
		oe_d[0], oe_c[0], oe_b[0], oe_a[0]};
	assign tmr_out = {tmr_out_b_i[5], tmr_out_a_i[5],
		tmr_out_b_i[4], tmr_out_a_i[4],
		tmr_out_d_i[1], tmr_out_c_i[1],
		tmr_out_b_i[3], tmr_out_a_i[3],
		tmr_out_b_i[2], tmr_out_a_i[2],
		tmr_out_b_i[1], tmr_out_a_i[1],
		tmr_out_d_i[0], tmr_out_c_i[0],
		tmr_out_b_i[0], tmr_out_a_i[0]};

	// Port function control gates timer ownership per port
	assign func_mask = {{8{st.func[`FUNC_K_BIT]}},
		{8{st.func[`FUNC_J_BIT]}}};
	assign eff_oe = raw_oe & func_mask;
	assign gpo_sel = ~eff_oe & st.dir;
	assign idle_sel = ~(eff_oe | st.dir);
	assign css = {chip_select_field_hi_i, chip_select_field_lo_i};

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	pin_sync #(
		.WIDTH (16)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (pin_in_i),
		.q_o   (sync_lvl)
	);

	// ----------------------------------------
	// Bus decode helpers
	// ----------------------------------------
	assign bus_req = wb_cyc_i && wb_stb_i && !st.ack;
	assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		// Timer first, then direction, else input
		next_st.pin_oe = eff_oe | st.dir;
		next_st.pin_out = (eff_oe & tmr_out)
			| (~eff_oe & st.data);
		// Chip select in master mode only
		next_st.per_oe[`POE_CS_BIT] = master_select_i
			&& ((css == `CSS_CS_OUT)
			|| ((css == `CSS_CS_AUTO)
			&& !sync_serial_mode_select_i));
		// Transmit pin follows transmit enable
		next_st.per_oe[`POE_TXD_BIT] = transmit_enable_bit_i;
		// Clock out with internal clock source
		next_st.per_oe[`POE_SCK_BIT] =
			(transmit_enable_bit_i || receive_enable_bit_i)
			&& (clock_enable_field_i == `CKE_CLOCK_OUT)
			&& (smart_card_interface_select_i
			? !smart_card_mode_bit_i
			: !sync_mode_bit_i);
		// Pulse output bit 15
		next_st.per_oe[`POE_PO15_BIT] = next_data_enable_15_i;
		// Ack drops the cycle after it is given
		next_st.ack = bus_req;
		next_st.rdat = '0;
		if (bus_req && wb_we_i) begin
			// Writes, per byte lane
			if (wb_adr_i == `ADDR_PORT_DATA) begin
				next_st.data = (wb_dat_i[15:0] & lane_mask)
					| (st.data & ~lane_mask);
			end else if (wb_adr_i == `ADDR_PORT_DIR) begin
				next_st.dir = (wb_dat_i[15:0] & lane_mask)
					| (st.dir & ~lane_mask);
			end else if (wb_adr_i == `ADDR_PORT_FUNC) begin
				if (wb_sel_i[0]) begin
					next_st.func = wb_dat_i[1:0];
				end
			end
		end else if (bus_req) begin
			// Reads; unmapped reads return zero
			if (wb_adr_i == `ADDR_PORT_DATA) begin
				next_st.rdat = {16'h0000, st.data};
			end else if (wb_adr_i == `ADDR_PORT_DIR) begin
				next_st.rdat = {16'h0000, st.dir};
			end else if (wb_adr_i == `ADDR_PORT_FUNC) begin
				next_st.rdat = {30'h00000000, st.func};
			end else if (wb_adr_i == `ADDR_PIN_LEVEL) begin
				next_st.rdat = {16'h0000, sync_lvl};
			end else if (wb_adr_i == `ADDR_PIN_OE) begin
				next_st.rdat = {16'h0000, st.pin_oe};
			end else if (wb_adr_i == `ADDR_PERIPH_OE) begin
				next_st.rdat = {28'h0000000, st.per_oe};
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= RESET_ST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_dat_o = st.rdat;
	assign wb_ack_o = st.ack;
	assign pin_out_o = st.pin_out;
	assign pin_oe_o = st.pin_oe;
	assign pin_level_o = sync_lvl;
	assign chip_select_output_enable_o = st.per_oe[`POE_CS_BIT];
	assign transmit_pin_output_enable_o = st.per_oe[`POE_TXD_BIT];
	assign serial_clock_output_enable_o = st.per_oe[`POE_SCK_BIT];
	assign pulse_out15_enable_o = st.per_oe[`POE_PO15_BIT];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Enable is exactly timer ownership or direction
	property p_mux_oe;
		!rst_i |=> (pin_oe_o == ($past(eff_oe) | $past(st.dir)));
	endproperty
	a_mux_oe: assert property (p_mux_oe)
		else $error("pin enable not from ownership and direction");

	// Timer owned pins carry the timer level
	property p_timer_drive;
		!rst_i |=> (((pin_out_o ^ $past(tmr_out))
			& $past(eff_oe)) == 16'h0000);
	endproperty
	a_timer_drive: assert property (p_timer_drive)
		else $error("timer owned pin not driven by timer");

	// Output pins carry port data
	property p_gpo_drive;
		!rst_i |=> (((pin_out_o ^ $past(st.data))
			& $past(gpo_sel)) == 16'h0000);
	endproperty
	a_gpo_drive: assert property (p_gpo_drive)
		else $error("output pin not driven by port data");

	// Input pins are never driven
	property p_idle_input;
		!rst_i |=> ((pin_oe_o & $past(idle_sel)) == 16'h0000);
	endproperty
	a_idle_input: assert property (p_idle_input)
		else $error("input pin is driven");

	// Channel 6 A field takes pin J0 when valid
	property p_a_field;
		(!tmr_io_a_i[3] && (tmr_io_a_i[1:0] != 2'h0)
			&& st.func[0]) |=> (pin_oe_o[0] && pin_out_o[0]
			== $past(tmr_out_a_i[0]));
	endproperty
	a_a_field: assert property (p_a_field)
		else $error("A field did not take its pin");

	// Channel 6 B field with bit 3 set never drives J1
	property p_b_field;
		(tmr_io_b_i[3] && !st.dir[1]) |=> !pin_oe_o[1];
	endproperty
	a_b_field: assert property (p_b_field)
		else $error("disabled B field drove its pin");

	// Buffer mode A holds C output off pin J2
	property p_c_buffer;
		(buffer_mode_a_i[0] && !st.dir[2]) |=> !pin_oe_o[2];
	endproperty
	a_c_buffer: assert property (p_c_buffer)
		else $error("buffered C channel drove its pin");

	// Chip select needs master mode
	property p_cs_master;
		!master_select_i |=> !chip_select_output_enable_o;
	endproperty
	a_cs_master: assert property (p_cs_master)
		else $error("chip select enabled without master mode");

	// Transmit pin enable follows transmit enable
	property p_txd;
		transmit_enable_bit_i ##1 transmit_enable_bit_i
			|-> transmit_pin_output_enable_o;
	endproperty
	a_txd: assert property (p_txd)
		else $error("transmit pin enable missing");

	// Clock pin needs clock field 01
	property p_sck_field;
		(clock_enable_field_i != 2'h1)
			|=> !serial_clock_output_enable_o;
	endproperty
	a_sck_field: assert property (p_sck_field)
		else $error("clock pin enabled with wrong clock field");

	// Pulse enable tracks next-data enable
	property p_po15;
		!rst_i |=> (pulse_out15_enable_o
			== $past(next_data_enable_15_i));
	endproperty
	a_po15: assert property (p_po15)
		else $error("pulse enable does not follow next-data bit");

endmodule

// >>> port_jk_board_model.sv
// ----------------------------------------
// Board side of the port J and K pads
// ----------------------------------------
module port_jk_board_model (
	input  wire logic [15:0] pin_out_i, // Device drive level
	input  wire logic [15:0] pin_oe_i,  // Device drive enable
	input  wire logic [15:0] ext_en_i,  // Board driver active
	input  wire logic [15:0] ext_val_i, // Board driver level
	output logic      [15:0] pad_o      // Resolved pad level
);
	timeunit 1ns;
	timeprecision 100ps;

	// Pad resolution, pull-up where nobody drives
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (pin_oe_i[i]) begin
				pad_o[i] = pin_out_i[i]; // Device owns the pad
			end else if (ext_en_i[i]) begin
				pad_o[i] = ext_val_i[i]; // Board owns the pad
			end else begin
				pad_o[i] = 1'b1; // Released pad floats high
			end
		end
	end
endmodule

// >>> port_jk_pin_function_mux_bench.sv
module port_jk_pin_function_mux_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, nde;
	logic [7:0]  wb_adr, io_c, io_d;
	logic [3:0]  wb_sel, sync_serial_unit, per_oe;
	logic [31:0] wb_wdat, wb_rdat, rd, ex;
	logic [23:0] io_a, io_b;
	logic [5:0]  out_a, out_b;
	logic [1:0]  bm_a, bm_b, out_c, out_d, func_s;
	logic [6:0]  sci;     // Transmit, receive, clock field, card, gm, sync
	logic [15:0] pad, pout, poe, plevel, ext_en, ext_val, data_s, dir_s;
	int          fail_count, samples_checked, cycles;

	port_jk_pin_function_mux DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .tmr_io_a_i(io_a),
		.tmr_io_b_i(io_b), .tmr_io_c_i(io_c), .tmr_io_d_i(io_d),
		.buffer_mode_a_i(bm_a), .buffer_mode_b_i(bm_b),
		.tmr_out_a_i(out_a), .tmr_out_b_i(out_b), .tmr_out_c_i(out_c),
		.tmr_out_d_i(out_d), .master_select_i(sync_serial_unit[3]),
		.chip_select_field_hi_i(sync_serial_unit[2]), .chip_select_field_lo_i(sync_serial_unit[1]),
		.sync_serial_mode_select_i(sync_serial_unit[0]),
		.transmit_enable_bit_i(sci[6]), .receive_enable_bit_i(sci[5]),
		.clock_enable_field_i(sci[4:3]),
		.smart_card_interface_select_i(sci[2]),
		.smart_card_mode_bit_i(sci[1]), .sync_mode_bit_i(sci[0]),
		.next_data_enable_15_i(nde), .pin_in_i(pad), .pin_out_o(pout),
		.pin_oe_o(poe), .pin_level_o(plevel),
		.chip_select_output_enable_o(per_oe[0]),
		.transmit_pin_output_enable_o(per_oe[1]),
		.serial_clock_output_enable_o(per_oe[2]),
		.pulse_out15_enable_o(per_oe[3]));

	port_jk_board_model board (.pin_out_i(pout), .pin_oe_i(poe),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad));

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Cut the run short if it hangs
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			test_done();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compare one value, report and count a difference
	task automatic check(input string nm, input logic [31:0] seen,
			input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One classic Wishbone cycle, held until ack is sampled
	task automatic wb_xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		wb_sel <= s;
		// Sample ack at each rising edge; take data at that same edge
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (wb_ack !== 1'b1) fail_count++; // No answer counts as a fault
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	// Read a register and compare it
	task automatic rd_chk(input string nm, input logic [7:0] a,
			input logic [31:0] exp);
		wb_xfer(1'b0, a, 32'h0000_0000, 4'h3);
		check(nm, rd, exp);
	endtask

	// Let launched inputs pass the output registers
	task automatic settle();
		@(posedge clk_i);
		@(negedge clk_i);
	endtask

	// Timer ownership of one channel field
	function automatic logic toe(input logic [3:0] f, input logic bm);
		return !f[3] && f[1:0] != 2'h0 && !bm;
	endfunction

	// Expected {pin_out, pin_oe} from the current settings
	function automatic logic [31:0] exp_pins();
		logic [15:0] own, tout;
		int c;
		for (int b = 0; b < 2; b++) begin
			c = 3 * b;
			own[8*b+2] = toe(io_c[4*b +: 4], bm_a[b]);
			tout[8*b+2] = out_c[b];
			own[8*b+3] = toe(io_d[4*b +: 4], bm_b[b]);
			tout[8*b+3] = out_d[b];
			for (int k = 0; k < 3; k++) begin
				own[8*b+2*k+(k>0)*2] = toe(io_a[4*(c+k) +: 4], 1'b0);
				tout[8*b+2*k+(k>0)*2] = out_a[c+k];
				own[8*b+2*k+1+(k>0)*2] = toe(io_b[4*(c+k) +: 4], 1'b0);
				tout[8*b+2*k+1+(k>0)*2] = out_b[c+k];
			end
		end
		own = own & {{8{func_s[1]}}, {8{func_s[0]}}};
		return {(own & tout) | (~own & data_s), own | dir_s};
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
		{io_a, io_b, io_c, io_d, bm_a, bm_b} = '0;
		{out_a, out_b, out_c, out_d, sync_serial_unit, sci, nde} = '0;
		{ext_en, ext_val, fail_count, samples_checked, cycles} = '0;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		check("reset pin_oe", poe, 32'h0);
		check("reset enables", per_oe, 32'h0);
		rd_chk("reset data", 8'h00, 32'h0000_0000);
		rd_chk("reset dir", 8'h04, 32'h0000_0000);
		rd_chk("reset func", 8'h08, 32'h0000_0003);
		// Unmapped and read-only places
		wb_xfer(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
		rd_chk("unmapped", 8'h20, 32'h0000_0000);
		wb_xfer(1'b1, 8'h10, 32'h0000_FFFF, 4'h3);
		rd_chk("pin_oe reg", 8'h10, 32'h0000_0000);
		// Lane select writes only the K byte
		wb_xfer(1'b1, 8'h00, 32'h0000_1234, 4'h2);
		rd_chk("data lane", 8'h00, 32'h0000_1200);
		data_s = 16'h5AA5;
		dir_s = 16'h0F3C;
		wb_xfer(1'b1, 8'h00, {16'h0, data_s}, 4'h3);
		wb_xfer(1'b1, 8'h04, {16'h0, dir_s}, 4'h3);
		settle();
		check("gpio oe", poe, dir_s);
		check("gpio out", pout & dir_s, data_s & dir_s);
		// Every field code, buffer mode and function setting
		func_s = 2'h3;
		for (int v = 0; v < 256; v++) begin
			if (v[5:0] == 0) begin
				func_s = v[7:6];
				wb_xfer(1'b1, 8'h08, {30'h0, func_s}, 4'h1);
			end
			@(posedge clk_i);
			io_a <= {6{v[3:0]}};
			io_b <= {6{v[3:0] + 4'h1}};
			io_c <= {2{v[3:0] ^ 4'h2}};
			io_d <= {2{v[3:0]}};
			bm_a <= v[5:4];
			bm_b <= {v[4], v[5]};
			out_a <= v[5:0];
			out_b <= ~v[5:0];
			out_c <= v[2:1];
			out_d <= v[1:0];
			settle();
			ex = exp_pins();
			check("pin_oe", poe, ex[15:0]);
			check("pin_out", pout & ex[15:0], ex[31:16] & ex[15:0]);
		end
		rd_chk("pin_oe reg", 8'h10, {16'h0, ex[15:0]});
		// Pad levels reach the inputs whatever the function
		ext_en <= 16'hFFFF;
		ext_val <= 16'hC33C;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		ex[15:0] = (ex[31:16] & ex[15:0]) | (16'hC33C & ~ex[15:0]);
		check("pin level", plevel, ex[15:0]);
		rd_chk("level reg", 8'h0C, {16'h0, ex[15:0]});
		// Serial, chip-select and pulse enables over every combination
		for (int v = 0; v < 4096; v++) begin
			@(posedge clk_i);
			sync_serial_unit <= v[3:0];
			sci <= v[10:4];
			nde <= v[11];
			settle();
			check("cs oe", per_oe[0], sync_serial_unit[3] & (sync_serial_unit[2:1] == 2'h2 |
				(sync_serial_unit[2:1] == 2'h3 & !sync_serial_unit[0])));
			check("txd oe", per_oe[1], sci[6]);
			check("sck oe", per_oe[2], (sci[6] | sci[5]) &
				sci[4:3] == 2'h1 & (sci[2] ? !sci[1] : !sci[0]));
			check("pulse oe", per_oe[3], nde);
		end
		rd_chk("enables reg", 8'h14, 32'h0000_000A);
		// A second reset mid-run returns every pin to input
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		{sync_serial_unit, sci, nde} <= '0;
		@(negedge clk_i);
		check("rerun oe", poe, 32'h0);
		rd_chk("rerun func", 8'h08, 32'h0000_0003);
		test_done();
	end
endmodule
